// *** hdl/lmu_top.sv ***
`timescale 1ns/1ps
module lmu_top #(
   parameter int unsigned CYC_PER_MS = lmu_pkg::CYC_PER_MS_DFLT,
   parameter int          SINK_N     = lmu_pkg::SINK_N
) (
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire logic              clk_en,
   input  wire logic              chip_en,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe,
   input  wire logic              strobe_trigger_pin,
   input  wire logic              thermal_guard,
   input  wire logic [SINK_N-1:0] open_fault,
   output logic [SINK_N-1:0]      sink_active,
   output logic [4:0]             bl_applied_code,
   output logic                   bl_low_bias,
   output logic                   strobe_sink_out,
   output logic [2:0]             strobe_level_out,
   output logic                   strobe_range_out,
   output logic                   strobe_timed_out,
   output logic                   sleep_state
);
   import lmu_pkg::*;

   // 32 bits cover a full second at the default clock
   localparam logic [31:0] GUARD_CYC = 32'(GUARD_S * MS_PER_S * CYC_PER_MS);

   lmu_reg_if rb ();

   // register fields
   logic [1:0]        fade_sel_q;
   logic              fade_on_q;
   logic [4:0]        sink_level_code_q;
   logic [SINK_N-1:0] sink_on_bits_q;
   logic              strobe_guard_timer_on_q;
   logic [2:0]        strobe_level_code_q;
   logic              strobe_range_sel_q;

   // engine state
   logic [4:0]        cur_q;
   logic [31:0]       step_cnt_q;
   logic [31:0]       guard_cnt_q;
   logic              timed_out_q;
   logic [SINK_N-1:0] float_q;

   // decode and status
   logic [SINK_N-1:0] bl_on;
   logic [31:0]       step_cyc;
   logic              ramping;
   logic              wr_bl;
   logic              wr_en;
   logic              wr_stb;
   logic              strobe_on;
   logic              asleep;

   lmu_i2c_slave u_i2c (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .rb      (rb),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .sda_oe  (sda_oe)
   );

   // open drain: only ever pulls low
   assign sda_o  = 1'b0;
   assign rb.ce  = clk_en;
   assign rb.clr = ~chip_en;

   // step length in ms per interval code
   function automatic int unsigned fade_ms(input logic [1:0] sel);
      case (sel)
         2'b00:   fade_ms = FADE_MS_00;
         2'b01:   fade_ms = FADE_MS_01;
         2'b10:   fade_ms = FADE_MS_10;
         default: fade_ms = FADE_MS_11;
      endcase
   endfunction

   assign step_cyc = 32'(fade_ms(fade_sel_q) * CYC_PER_MS);
   assign ramping  = fade_on_q & (cur_q != sink_level_code_q);
   assign wr_bl    = rb.wr_stb & (rb.ptr == REG_BL_OFS);
   assign wr_en    = rb.wr_stb & (rb.ptr == REG_EN_OFS);
   assign wr_stb   = rb.wr_stb & (rb.ptr == REG_STB_OFS);

   // register bank; chip enable low acts as a synchronous clear
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         fade_sel_q <= BL_RST[FADE_MSB:FADE_LSB];
         fade_on_q  <= BL_RST[FADE_EN_POS];
      end else if (clk_en) begin
         if (!chip_en) begin
            fade_sel_q <= BL_RST[FADE_MSB:FADE_LSB];
            fade_on_q  <= BL_RST[FADE_EN_POS];
         end else if (wr_bl) begin
            fade_sel_q <= rb.wr_data[FADE_MSB:FADE_LSB];
            fade_on_q  <= rb.wr_data[FADE_EN_POS];
         end
      end
   end

   // level is frozen while stepping
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sink_level_code_q <= BL_RST[LVL_MSB:0];
      end else if (clk_en) begin
         if (!chip_en) begin
            sink_level_code_q <= BL_RST[LVL_MSB:0];
         end else if (wr_bl && !ramping) begin
            sink_level_code_q <= rb.wr_data[LVL_MSB:0];
         end
      end
   end

   // upper bits are not stored, so stray ones are harmless
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sink_on_bits_q <= EN_RST[SINK_N-1:0];
      end else if (clk_en) begin
         if (!chip_en) begin
            sink_on_bits_q <= EN_RST[SINK_N-1:0];
         end else if (wr_en) begin
            sink_on_bits_q <= rb.wr_data[SINK_N-1:0];
         end
      end
   end

   // strobe control register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobe_guard_timer_on_q <= STB_RST[GUARD_POS];
         strobe_level_code_q     <= STB_RST[SLVL_MSB:SLVL_LSB];
         strobe_range_sel_q      <= STB_RST[RANGE_POS];
      end else if (clk_en) begin
         if (!chip_en) begin
            strobe_guard_timer_on_q <= STB_RST[GUARD_POS];
            strobe_level_code_q     <= STB_RST[SLVL_MSB:SLVL_LSB];
            strobe_range_sel_q      <= STB_RST[RANGE_POS];
         end else if (wr_stb) begin
            strobe_guard_timer_on_q <= rb.wr_data[GUARD_POS];
            strobe_level_code_q     <= rb.wr_data[SLVL_MSB:SLVL_LSB];
            strobe_range_sel_q      <= rb.wr_data[RANGE_POS];
         end
      end
   end

   // read back stored values, level as programmed target
   always_comb begin
      rb.rd_data = RD_UNMAPPED;
      case (rb.ptr)
         REG_BL_OFS:  rb.rd_data = {fade_sel_q, fade_on_q, sink_level_code_q};
         REG_EN_OFS:  rb.rd_data[SINK_N-1:0] = sink_on_bits_q;
         REG_STB_OFS: rb.rd_data[GUARD_POS:0] = {strobe_guard_timer_on_q, strobe_level_code_q,
                                                 strobe_range_sel_q};
         default:     rb.rd_data = RD_UNMAPPED;
      endcase
   end

   // fade engine; the interval is compared live so a new rate acts on the step already under way
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cur_q      <= BL_RST[LVL_MSB:0];
         step_cnt_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (!chip_en) begin
            cur_q      <= BL_RST[LVL_MSB:0];
            step_cnt_q <= 32'h0000_0000;
         end else if (!fade_on_q || asleep) begin
            // with fading off or in sleep, the level jumps straight to the target
            cur_q      <= sink_level_code_q;
            step_cnt_q <= 32'h0000_0000;
         end else if (cur_q != sink_level_code_q) begin
            if (step_cnt_q >= step_cyc - 32'h0000_0001) begin
               step_cnt_q <= 32'h0000_0000;
               if (cur_q < sink_level_code_q) cur_q <= cur_q + 5'h01;
               else cur_q <= cur_q - 5'h01;
            end else begin
               step_cnt_q <= step_cnt_q + 32'h0000_0001;
            end
         end else begin
            step_cnt_q <= 32'h0000_0000;
         end
      end
   end

   // per sink float latch, released by clearing that sink's enable
   genvar gi;
   generate
      for (gi = 0; gi < SINK_N; gi++) begin : g_sink
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               float_q[gi] <= 1'b0;
            end else if (clk_en) begin
               if (!chip_en) float_q[gi] <= 1'b0;
               else if (sink_on_bits_q[gi] && open_fault[gi]) float_q[gi] <= 1'b1;
               else if (!sink_on_bits_q[gi]) float_q[gi] <= 1'b0;
            end
         end
         assign bl_on[gi] = sink_on_bits_q[gi] & ~float_q[gi] & ~thermal_guard;
      end
   endgenerate

   // with the pin tied high, the register level, timeout and thermal guard alone gate the strobe
   assign strobe_on = strobe_trigger_pin & (strobe_level_code_q != STRB_OFF)
                      & ~timed_out_q & ~thermal_guard;
   assign asleep    = ~(|bl_on) & ~strobe_on;

   // strobe safety timer latch
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timed_out_q <= 1'b0;
      end else if (clk_en) begin
         if (!chip_en) begin
            timed_out_q <= 1'b0;
         end else if (!strobe_trigger_pin || strobe_level_code_q == STRB_OFF) begin
            timed_out_q <= 1'b0;
         end else if (!strobe_guard_timer_on_q) begin
            timed_out_q <= 1'b0;
         end else if (strobe_on && guard_cnt_q >= GUARD_CYC - 32'h0000_0001) begin
            timed_out_q <= 1'b1;
         end
      end
   end

   // counts only while the sink really conducts; any gap restarts it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         guard_cnt_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (!chip_en) begin
            guard_cnt_q <= 32'h0000_0000;
         end else if (strobe_on && strobe_guard_timer_on_q
                      && guard_cnt_q < GUARD_CYC - 32'h0000_0001) begin
            guard_cnt_q <= guard_cnt_q + 32'h0000_0001;
         end else begin
            guard_cnt_q <= 32'h0000_0000;
         end
      end
   end

   // registered pin-side outputs, backlight side
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sink_active     <= '0;
         bl_applied_code <= BL_RST[LVL_MSB:0];
         bl_low_bias     <= 1'b1;
      end else if (clk_en) begin
         sink_active     <= bl_on;
         bl_applied_code <= cur_q;
         bl_low_bias     <= (cur_q <= LOW_BIAS_MAX);
      end
   end

   // registered pin-side outputs, strobe side
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         strobe_sink_out  <= 1'b0;
         strobe_level_out <= STRB_OFF;
         strobe_range_out <= STB_RST[RANGE_POS];
         strobe_timed_out <= 1'b0;
      end else if (clk_en) begin
         strobe_sink_out  <= strobe_on;
         strobe_level_out <= strobe_on ? strobe_level_code_q : STRB_OFF;
         strobe_range_out <= strobe_range_sel_q;
         strobe_timed_out <= timed_out_q;
      end
   end

   // sleep flag
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sleep_state <= 1'b1;
      end else if (clk_en) begin
         sleep_state <= asleep;
      end
   end
endmodule

// *** inc/lmu_pkg.sv ***
package lmu_pkg;
   // register offsets and reset values
   localparam logic [7:0] REG_BL_OFS  = 8'h00;
   localparam logic [7:0] REG_EN_OFS  = 8'h01;
   localparam logic [7:0] REG_STB_OFS = 8'h02;
   localparam logic [7:0] BL_RST      = 8'h00;
   localparam logic [7:0] EN_RST      = 8'h00;
   localparam logic [7:0] STB_RST     = 8'h10;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // field positions
   localparam int FADE_MSB    = 7;
   localparam int FADE_LSB    = 6;
   localparam int FADE_EN_POS = 5;
   localparam int LVL_MSB     = 4;
   localparam int SINK_N      = 4;
   localparam int GUARD_POS   = 4;
   localparam int SLVL_MSB    = 3;
   localparam int SLVL_LSB    = 1;
   localparam int RANGE_POS   = 0;

   // timing
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned US_PER_MS       = 1000;
   localparam int unsigned MS_PER_S        = 1000;
   localparam int unsigned CYC_PER_MS_DFLT = CLK_MHZ * US_PER_MS;
   localparam int unsigned FADE_MS_00      = 32;
   localparam int unsigned FADE_MS_01      = 24;
   localparam int unsigned FADE_MS_10      = 16;
   localparam int unsigned FADE_MS_11      = 8;
   localparam int unsigned GUARD_S         = 1;

   // codes
   localparam logic [4:0] LOW_BIAS_MAX = 5'h07;
   localparam logic [2:0] STRB_OFF     = 3'h0;
   localparam logic [6:0] DEV_ADDR     = 7'h37;

   typedef enum logic [2:0] {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_MACK} lmu_i2c_st_t;
endpackage

// *** inc/lmu_reg_if.sv ***
`timescale 1ns/1ps
interface lmu_reg_if;
   logic       ce;
   logic       clr;
   logic       wr_stb;
   logic [7:0] ptr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   modport slave (input ce, input clr, input rd_data, output wr_stb, output ptr, output wr_data);
   modport regs (output ce, output clr, output rd_data, input wr_stb, input ptr, input wr_data);
endinterface

// *** hdl/lmu_i2c_slave.sv ***
`timescale 1ns/1ps
module lmu_i2c_slave (
   input  wire logic ref_clk,
   input  wire logic rstn,
   lmu_reg_if.slave  rb,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_oe
);
   import lmu_pkg::*;

   lmu_i2c_st_t st_q;
   logic        scl_q;
   logic        sda_q;
   logic        rw_q;
   logic        nack_q;
   logic        oe_q;
   logic        wr_stb_q;
   logic [3:0]  bit_q;
   logic [1:0]  byte_q;
   logic [7:0]  sh_q;
   logic [7:0]  ptr_q;
   logic        scl_rise;
   logic        scl_fall;
   logic        start;
   logic        stop;

   assign scl_rise   = scl_i & ~scl_q;
   assign scl_fall   = ~scl_i & scl_q;
   assign start      = scl_i & scl_q & sda_q & ~sda_i;
   assign stop       = scl_i & scl_q & ~sda_q & sda_i;
   assign sda_oe     = oe_q;
   assign rb.wr_stb  = wr_stb_q;
   assign rb.wr_data = sh_q;
   assign rb.ptr     = ptr_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (rb.ce) begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // no auto increment: the pointer stays until the next pointer byte
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q     <= I2C_IDLE;
         rw_q     <= 1'b0;
         nack_q   <= 1'b0;
         oe_q     <= 1'b0;
         wr_stb_q <= 1'b0;
         bit_q    <= 4'h0;
         byte_q   <= 2'h0;
         sh_q     <= 8'h00;
         ptr_q    <= 8'h00;
      end else if (rb.ce) begin
         wr_stb_q <= 1'b0;
         if (rb.clr || stop) begin
            st_q <= I2C_IDLE;
            oe_q <= 1'b0;
            if (rb.clr) ptr_q <= 8'h00;
         end else if (start) begin
            st_q   <= I2C_RX;
            bit_q  <= 4'h0;
            byte_q <= 2'h0;
            oe_q   <= 1'b0;
         end else begin
            case (st_q)
               I2C_RX: begin
                  if (scl_rise && bit_q != 4'h8) begin
                     sh_q  <= {sh_q[6:0], sda_i};
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     st_q  <= I2C_ACK;
                     oe_q  <= 1'b1;
                     if (byte_q == 2'h0) begin
                        rw_q <= sh_q[0];
                        if (sh_q[7:1] != DEV_ADDR) begin
                           st_q <= I2C_IDLE;
                           oe_q <= 1'b0;
                        end
                     end else if (byte_q == 2'h1) begin
                        ptr_q <= sh_q;
                     end else begin
                        wr_stb_q <= 1'b1;
                     end
                  end
               end
               I2C_ACK: begin
                  if (scl_fall) begin
                     oe_q <= 1'b0;
                     if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
                     if (rw_q && byte_q == 2'h0) begin
                        st_q <= I2C_TX;
                        sh_q <= rb.rd_data;
                        oe_q <= ~rb.rd_data[7];
                     end else begin
                        st_q <= I2C_RX;
                     end
                  end
               end
               I2C_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h7) begin
                        st_q <= I2C_MACK;
                        oe_q <= 1'b0;
                     end else begin
                        sh_q  <= {sh_q[6:0], 1'b0};
                        oe_q  <= ~sh_q[6];
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               I2C_MACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_i;
                  end else if (scl_fall) begin
                     bit_q <= 4'h0;
                     if (nack_q) begin
                        st_q <= I2C_IDLE;
                     end else begin
                        st_q <= I2C_TX;
                        sh_q <= rb.rd_data;
                        oe_q <= ~rb.rd_data[7];
                     end
                  end
               end
               default: st_q <= I2C_IDLE;
            endcase
         end
      end
   end
endmodule

// *** testbench/lmu_top_props.sv ***
`timescale 1ns/1ps
module lmu_top_props #(
   parameter int unsigned CYC_PER_MS = lmu_pkg::CYC_PER_MS_DFLT,
   parameter int          SINK_N     = lmu_pkg::SINK_N
) (
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              chip_en,
   input wire logic              strobe_trigger_pin,
   input wire logic              thermal_guard,
   input wire logic [SINK_N-1:0] open_fault,
   input wire logic [SINK_N-1:0] sink_active,
   input wire logic [4:0]        bl_applied_code,
   input wire logic              bl_low_bias,
   input wire logic              strobe_sink_out,
   input wire logic [2:0]        strobe_level_out,
   input wire logic              strobe_timed_out,
   input wire logic              sleep_state
);
   import lmu_pkg::*;
   localparam int unsigned GUARD_CYC = GUARD_S * MS_PER_S * CYC_PER_MS;
   logic [31:0] on_cnt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // unbroken on time; any gap restarts it, matching the continuous-on timeout
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         on_cnt_q <= '0;
      end else if (strobe_sink_out) begin
         on_cnt_q <= on_cnt_q + 32'h0000_0001;
      end else begin
         on_cnt_q <= '0;
      end
   end
   a_thermal_all_off: assert property (
      thermal_guard && $past(thermal_guard) |-> sink_active == '0 && !strobe_sink_out)
      else $error("output on during thermal fault");
   a_pin_low_off: assert property (
      !strobe_trigger_pin && $past(!strobe_trigger_pin) |-> !strobe_sink_out)
      else $error("strobe on with trigger low");
   a_level_zero_off: assert property (
      strobe_sink_out == (strobe_level_out != STRB_OFF))
      else $error("strobe state and level disagree");
   a_low_bias_code: assert property (
      $stable(bl_applied_code) [*2] |-> bl_low_bias == (bl_applied_code <= LOW_BIAS_MAX))
      else $error("low bias flag wrong");
   a_timeout_kills: assert property (
      strobe_timed_out && $past(strobe_timed_out) |-> !strobe_sink_out)
      else $error("strobe on after timeout");
   a_timeout_moment: assert property (
      $rose(strobe_timed_out) |-> on_cnt_q + 3 >= GUARD_CYC && on_cnt_q <= GUARD_CYC + 3)
      else $error("timeout at wrong on time");
   a_dark_sleeps: assert property (
      (sink_active == '0 && !strobe_sink_out) [*3] |-> sleep_state)
      else $error("no sleep with all sinks off");
   a_fault_sink_off: assert property (
      (open_fault & $past(open_fault) & $past(open_fault, 2) & sink_active) == '0)
      else $error("faulted sink still on");
   a_chip_off_idle: assert property (
      !chip_en [*3] |-> sink_active == '0 && !strobe_sink_out && bl_applied_code == 5'h00)
      else $error("outputs live with chip disabled");
endmodule
bind lmu_top lmu_top_props #(.CYC_PER_MS(CYC_PER_MS), .SINK_N(SINK_N)) u_props (
   .ref_clk(ref_clk), .rstn(rstn), .chip_en(chip_en), .strobe_trigger_pin(strobe_trigger_pin),
   .thermal_guard(thermal_guard), .open_fault(open_fault), .sink_active(sink_active),
   .bl_applied_code(bl_applied_code), .bl_low_bias(bl_low_bias),
   .strobe_sink_out(strobe_sink_out), .strobe_level_out(strobe_level_out),
   .strobe_timed_out(strobe_timed_out), .sleep_state(sleep_state));

// *** testbench/lmu_i2c_host.sv ***
`timescale 1ns/1ps
module lmu_i2c_host (
   input  wire logic ref_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   import lmu_pkg::*;
   logic ack_q;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      ack_q = 1'b1;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // 4-cycle high phase; the slave samples sda on the first cycle that it sees scl high
   task automatic clk_bit(input logic b, output logic seen);
      sda_drv <= b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      seen = sda_line;
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic start_cond();
      sda_drv <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask
   task automatic stop_cond();
      sda_drv <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(4);
   endtask
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], b);
         rx[i] = b;
      end
      clk_bit(mack, b);
      ack_q = b;
   endtask
   task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data);
      logic [7:0] rx;
      start_cond();
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx);
      xfer(ptr, 1'b1, rx);
      xfer(data, 1'b1, rx);
      stop_cond();
   endtask
   // combined format; the final bit is left released as a nack to end the read
   task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
      logic [7:0] rx;
      start_cond();
      xfer({DEV_ADDR, 1'b0}, 1'b1, rx);
      xfer(ptr, 1'b1, rx);
      start_cond();
      xfer({DEV_ADDR, 1'b1}, 1'b1, rx);
      xfer(8'hFF, 1'b1, data);
      stop_cond();
   endtask
endmodule

// *** testbench/lmu_top_bench.sv ***
`timescale 1ns/1ps
module lmu_top_bench;
   import lmu_pkg::*;
   localparam int unsigned CPM = 4;
   logic        ref_clk, rstn, clk_en, chip_en, trig, therm, scl, sda_drv, sda_i, sda_o, sda_oe;
   logic [3:0]  fault, sinks;
   logic [4:0]  code;
   logic [2:0]  st_lvl;
   logic        bias, st_on, st_rng, st_to, sleep;
   logic [7:0]  v;
   int          fails, compares, n;
   int unsigned ms [4] = '{FADE_MS_00, FADE_MS_01, FADE_MS_10, FADE_MS_11};
   lmu_top #(.CYC_PER_MS(CPM)) dut (
      .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .chip_en(chip_en), .scl_i(scl),
      .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .strobe_trigger_pin(trig),
      .thermal_guard(therm), .open_fault(fault), .sink_active(sinks), .bl_applied_code(code),
      .bl_low_bias(bias), .strobe_sink_out(st_on), .strobe_level_out(st_lvl),
      .strobe_range_out(st_rng), .strobe_timed_out(st_to), .sleep_state(sleep));
   lmu_i2c_host host (.ref_clk(ref_clk), .sda_line(sda_i), .scl(scl), .sda_drv(sda_drv));
   // pulled-up open drain line
   assign sda_i = sda_drv & ~sda_oe;
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic results();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   task automatic bound(input int k, input int lim);
      if (k >= lim) begin
         fails++;
         $display("FAIL wait expected done seen timeout");
         results();
      end
   endtask
   task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
      host.read_reg(ptr, v);
      check("reg", v, exp);
   endtask
   task automatic wait_code(input logic [4:0] tgt, input int lim);
      logic [4:0] prev;
      prev = code;
      n = 0;
      while (code !== tgt && n < lim) begin
         cyc(1);
         n++;
         if (code !== prev) begin
            check("step", code == prev + 5'h01 || code == prev - 5'h01, 8'h01);
            prev = code;
         end
      end
      bound(n, lim);
   endtask
   initial begin
      rstn = 1'b0;
      chip_en = 1'b1;
      clk_en = 1'b1;
      trig = 1'b0;
      therm = 1'b0;
      fault = 4'h0;
      fails = 0;
      compares = 0;
      cyc(16);
      rstn <= 1'b1;
      cyc(4);
      check("sleep", sleep, 8'h01);
      rd(REG_BL_OFS, BL_RST);
      rd(REG_EN_OFS, EN_RST);
      rd(REG_STB_OFS, STB_RST);
      rd(8'h03, RD_UNMAPPED);
      // sinks 2 and 4 stand for unconnected outputs and stay clear
      host.write_reg(REG_EN_OFS, 8'h05);
      check("ack", host.ack_q, 8'h00);
      check("sda_o", sda_o, 8'h00);
      host.write_reg(REG_BL_OFS, 8'h1F);
      cyc(4);
      check("code", code, 8'h1F);
      check("sinks", sinks, 8'h05);
      check("bias", bias, 8'h00);
      check("sleep", sleep, 8'h00);
      host.write_reg(REG_BL_OFS, 8'h07);
      cyc(4);
      check("bias", bias, 8'h01);
      host.write_reg(REG_BL_OFS, 8'h08);
      for (int f = 0; f < 4; f++) begin
         host.write_reg(REG_BL_OFS, {f[1:0], 1'b1, (f % 2 == 1) ? 5'h08 : 5'h0C});
         wait_code((f % 2 == 1) ? 5'h08 : 5'h0C, 3000);
         check("fade time", n + 28 >= 4 * ms[f] * CPM && n <= 4 * ms[f] * CPM + 4, 1);
      end
      host.write_reg(REG_BL_OFS, 8'h38);
      cyc(100);
      rd(REG_BL_OFS, 8'h38);
      host.write_reg(REG_BL_OFS, 8'h20);
      rd(REG_BL_OFS, 8'h38);
      host.write_reg(REG_BL_OFS, 8'hF8);
      wait_code(5'h18, 3000);
      check("fast rest", n <= 16 * FADE_MS_11 * CPM + 40, 1);
      host.write_reg(REG_BL_OFS, 8'h22);
      // clock enable low must hold the ramp on its starting code
      clk_en <= 1'b0;
      cyc(400);
      check("frozen", code, 8'h18);
      clk_en <= 1'b1;
      cyc(200);
      host.write_reg(REG_BL_OFS, 8'h02);
      cyc(4);
      check("code", code, 8'h02);
      host.write_reg(REG_STB_OFS, 8'h17);
      trig <= 1'b1;
      cyc(3);
      check("strobe", st_on, 8'h01);
      check("level", st_lvl, 8'h03);
      check("range", st_rng, 8'h01);
      n = 0;
      while (st_to !== 1'b1 && n < 5000) begin
         cyc(1);
         n++;
      end
      bound(n, 5000);
      check("guard time", n > 3980 && n < 4010, 1);
      cyc(2);
      check("strobe", st_on, 8'h00);
      trig <= 1'b0;
      cyc(3);
      check("timeout", st_to, 8'h00);
      trig <= 1'b1;
      host.write_reg(REG_STB_OFS, 8'h06);
      cyc(4200);
      check("strobe", st_on, 8'h01);
      check("range", st_rng, 8'h00);
      host.write_reg(REG_STB_OFS, 8'h00);
      cyc(3);
      check("strobe", st_on, 8'h00);
      host.write_reg(REG_STB_OFS, 8'h13);
      therm <= 1'b1;
      cyc(3);
      check("sinks", sinks, 8'h00);
      check("strobe", st_on, 8'h00);
      rd(REG_EN_OFS, 8'h05);
      therm <= 1'b0;
      cyc(3);
      check("sinks", sinks, 8'h05);
      check("strobe", st_on, 8'h01);
      fault <= 4'h1;
      cyc(3);
      check("sinks", sinks, 8'h04);
      fault <= 4'h0;
      chip_en <= 1'b0;
      cyc(4);
      check("sinks", sinks, 8'h00);
      chip_en <= 1'b1;
      trig <= 1'b0;
      cyc(4);
      rd(REG_BL_OFS, BL_RST);
      rd(REG_STB_OFS, STB_RST);
      check("sleep", sleep, 8'h01);
      results();
   end
endmodule
